// *** design/ppp_pkg.sv ***
// Package for the parallel printer port: register map, reset values, carriers
package ppp_pkg;
    // ****************************************
    // Register map (printed offsets are not all multiples of four: byte address = 4 * index)
    // ****************************************
    localparam logic [11:0] PPP_IDX_DATA    = 12'h0378;
    localparam logic [11:0] PPP_IDX_STATUS  = 12'h0379;
    localparam logic [11:0] PPP_IDX_CONTROL = 12'h037a;
    localparam logic [11:0] PPP_IDX_IRQ_ST  = 12'h037b;
    localparam logic [11:0] PPP_IDX_IRQ_MSK = 12'h037c;
    localparam logic [13:0] PPP_ADDR_DATA    = {PPP_IDX_DATA, 2'b00};
    localparam logic [13:0] PPP_ADDR_STATUS  = {PPP_IDX_STATUS, 2'b00};
    localparam logic [13:0] PPP_ADDR_CONTROL = {PPP_IDX_CONTROL, 2'b00};
    localparam logic [13:0] PPP_ADDR_IRQ_ST  = {PPP_IDX_IRQ_ST, 2'b00};
    localparam logic [13:0] PPP_ADDR_IRQ_MSK = {PPP_IDX_IRQ_MSK, 2'b00};

    // ****************************************
    // Field positions
    // ****************************************
    localparam int PPP_CTL_STROBE = 0;
    localparam int PPP_CTL_AUTOLF = 1;
    localparam int PPP_CTL_INIT   = 2;
    localparam int PPP_CTL_SELECT = 3;
    localparam int PPP_CTL_IRQEN  = 4;
    localparam int PPP_CTL_OUTDIS = 5;
    localparam int PPP_CTL_USED   = 6;
    localparam int PPP_ST_ERROR   = 3;
    localparam int PPP_ST_ONLINE  = 4;
    localparam int PPP_ST_PAPER   = 5;
    localparam int PPP_ST_ACK     = 6;
    localparam int PPP_ST_BUSY    = 7;
    localparam int PPP_IRQ_ACK    = 0;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] PPP_RST_DATA    = 8'h00;
    localparam logic [7:0] PPP_RST_CONTROL = 8'h0f;
    localparam logic [7:0] PPP_RST_IRQ     = 8'h00;
    localparam logic [2:0] PPP_RST_SYNC    = 3'b111;

    // Printer condition lines, as on the pins
    typedef struct packed {
        logic error_n;
        logic online_indication;
        logic paper_out_n;
        logic ack_n;
        logic busy;
    } ppp_status_t;

    // Host-driven control lines, as on the pins
    typedef struct packed {
        logic strobe_n;
        logic auto_line_feed_request_n;
        logic init_n;
        logic select_n;
    } ppp_ctrl_t;
endpackage : ppp_pkg

// *** design/ppp_port.sv ***
// Parallel printer port with APB register access
`timescale 1ns/1ps
module ppp_port (
    input  wire logic              i_core_clk,
    input  wire logic              i_nrst,
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [15:0]       i_paddr,
    input  wire logic [31:0]       i_pwdata,
    input  wire logic [3:0]        i_pstrb,
    output logic                   o_pready,
    output logic [31:0]            o_prdata,
    output logic                   o_pslverr,
    input  wire ppp_pkg::ppp_status_t i_status,
    input  wire logic [7:0]        i_data_in,
    output ppp_pkg::ppp_ctrl_t     o_ctrl,
    output logic [7:0]             o_data_out,
    output logic [7:0]             o_data_oe,
    output logic                   o_irq
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    localparam int NS = 5;
    logic [NS-1:0] s1_r, s2_r, s3_r, st_r;
    logic [NS-1:0] s1_nxt, s2_nxt, s3_nxt, st_nxt;
    logic [7:0]    d1_r, d2_r, d3_r, d1_nxt, d2_nxt, d3_nxt;

    always_comb begin
        s1_nxt = i_status;
        s2_nxt = s1_r;
        s3_nxt = s2_r;
        d1_nxt = i_data_in;
        d2_nxt = d1_r;
        d3_nxt = d2_r;
    end

    // A change is accepted once the second and third stages agree
    genvar g;
    generate
        for (g = 0; g < NS; g++) begin : g_filt
            always_comb begin
                st_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : st_r[g];
            end
        end
    endgenerate

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            s1_r <= {NS{1'b1}};
            s2_r <= {NS{1'b1}};
            s3_r <= {NS{1'b1}};
            st_r <= {NS{1'b1}};
            d1_r <= 8'h00;
            d2_r <= 8'h00;
            d3_r <= 8'h00;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            s3_r <= s3_nxt;
            st_r <= st_nxt;
            d1_r <= d1_nxt;
            d2_r <= d2_nxt;
            d3_r <= d3_nxt;
        end
    end

    ppp_pkg::ppp_status_t stat;
    assign stat = st_r;

    // ****************************************
    // Registers and APB slave
    // ****************************************
    logic [7:0]  data_r, data_nxt;
    logic [5:0]  ctl_r, ctl_nxt;
    logic        irq_st_r, irq_st_nxt;
    logic        irq_msk_r, irq_msk_nxt;
    logic        ack_d_r, ack_d_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic        err_r, err_nxt;
    logic        wr_acc, rd_acc, ack_fall, hit;
    logic [7:0]  status_byte;

    assign wr_acc   = i_psel && i_penable && i_pwrite;
    assign rd_acc   = i_psel && !i_penable && !i_pwrite;
    assign ack_fall = ack_d_r && !stat.ack_n;

    always_comb begin
        status_byte = 8'h00;
        status_byte[ppp_pkg::PPP_ST_ERROR]  = stat.error_n;
        status_byte[ppp_pkg::PPP_ST_ONLINE] = stat.online_indication;
        status_byte[ppp_pkg::PPP_ST_PAPER]  = stat.paper_out_n;
        status_byte[ppp_pkg::PPP_ST_ACK]    = stat.ack_n;
        status_byte[ppp_pkg::PPP_ST_BUSY]   = !stat.busy;
    end

    always_comb begin
        hit = (i_paddr[15:14] == 2'b00) &&
              ((i_paddr[13:0] == ppp_pkg::PPP_ADDR_DATA) ||
               (i_paddr[13:0] == ppp_pkg::PPP_ADDR_STATUS) ||
               (i_paddr[13:0] == ppp_pkg::PPP_ADDR_CONTROL) ||
               (i_paddr[13:0] == ppp_pkg::PPP_ADDR_IRQ_ST) ||
               (i_paddr[13:0] == ppp_pkg::PPP_ADDR_IRQ_MSK));
        data_nxt    = data_r;
        ctl_nxt     = ctl_r;
        irq_msk_nxt = irq_msk_r;
        irq_st_nxt  = irq_st_r;
        ack_d_nxt   = stat.ack_n;
        rdata_nxt   = rdata_r;
        err_nxt     = 1'b0;
        if (i_psel && !i_penable) begin
            err_nxt = !hit;
        end
        if (wr_acc && i_pstrb[0] && i_paddr[15:14] == 2'b00) begin
            case (i_paddr[13:0])
                ppp_pkg::PPP_ADDR_DATA:    data_nxt = i_pwdata[7:0];
                ppp_pkg::PPP_ADDR_CONTROL: ctl_nxt = i_pwdata[ppp_pkg::PPP_CTL_USED-1:0];
                ppp_pkg::PPP_ADDR_IRQ_MSK: irq_msk_nxt = i_pwdata[ppp_pkg::PPP_IRQ_ACK];
                ppp_pkg::PPP_ADDR_IRQ_ST:  if (i_pwdata[ppp_pkg::PPP_IRQ_ACK]) irq_st_nxt = 1'b0;
                default:                   data_nxt = data_r;
            endcase
        end
        // Set wins over a simultaneous write-one clear
        if (ack_fall && ctl_r[ppp_pkg::PPP_CTL_IRQEN]) begin
            irq_st_nxt = 1'b1;
        end
        if (rd_acc) begin
            case (i_paddr)
                {2'b00, ppp_pkg::PPP_ADDR_DATA}:    rdata_nxt = {24'h00_0000, data_r};
                {2'b00, ppp_pkg::PPP_ADDR_STATUS}:  rdata_nxt = {24'h00_0000, status_byte};
                {2'b00, ppp_pkg::PPP_ADDR_CONTROL}: rdata_nxt = {24'h00_0000, 2'b00, ctl_r};
                {2'b00, ppp_pkg::PPP_ADDR_IRQ_ST}:  rdata_nxt = {31'h0000_0000, irq_st_r};
                {2'b00, ppp_pkg::PPP_ADDR_IRQ_MSK}: rdata_nxt = {31'h0000_0000, irq_msk_r};
                default:                            rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            data_r    <= ppp_pkg::PPP_RST_DATA;
            ctl_r     <= ppp_pkg::PPP_RST_CONTROL[5:0];
            irq_st_r  <= 1'b0;
            irq_msk_r <= 1'b0;
            ack_d_r   <= 1'b1;
            rdata_r   <= 32'h0000_0000;
            err_r     <= 1'b0;
        end else begin
            data_r    <= data_nxt;
            ctl_r     <= ctl_nxt;
            irq_st_r  <= irq_st_nxt;
            irq_msk_r <= irq_msk_nxt;
            ack_d_r   <= ack_d_nxt;
            rdata_r   <= rdata_nxt;
            err_r     <= err_nxt;
        end
    end

    // Zero-wait slave: data and error are captured in the setup cycle
    assign o_pready  = 1'b1;
    assign o_prdata  = rdata_r;
    assign o_pslverr = i_psel && i_penable && err_r;

    // ****************************************
    // Printer pins
    // ****************************************
    assign o_ctrl.strobe_n                 = ctl_r[ppp_pkg::PPP_CTL_STROBE];
    assign o_ctrl.auto_line_feed_request_n = ctl_r[ppp_pkg::PPP_CTL_AUTOLF];
    assign o_ctrl.init_n                   = ctl_r[ppp_pkg::PPP_CTL_INIT];
    assign o_ctrl.select_n                 = ctl_r[ppp_pkg::PPP_CTL_SELECT];
    assign o_data_out = data_r;
    assign o_data_oe  = {8{!ctl_r[ppp_pkg::PPP_CTL_OUTDIS]}};
    assign o_irq      = irq_st_r && irq_msk_r;

    // ****************************************
    // Checks
    // ****************************************
    chk_strobe_follows: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        wr_acc && i_pstrb[0] && i_paddr == {2'b00, ppp_pkg::PPP_ADDR_CONTROL}
        |=> o_ctrl.strobe_n == $past(i_pwdata[0])) else $error("strobe write lost");
    chk_ctl_unused: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        rd_acc && i_paddr == {2'b00, ppp_pkg::PPP_ADDR_CONTROL}
        |=> o_prdata[31:6] == 26'h000_0000) else $error("unused control bits read back");
    chk_irq_clear: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        wr_acc && i_pstrb[0] && i_paddr == {2'b00, ppp_pkg::PPP_ADDR_IRQ_ST}
        && i_pwdata[0] && !ack_fall |=> !irq_st_r) else $error("irq status not cleared");
    chk_ctl_write_lands: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        wr_acc && i_pstrb[0] && i_paddr == {2'b00, ppp_pkg::PPP_ADDR_CONTROL}
        |=> o_ctrl.auto_line_feed_request_n == $past(i_pwdata[1]) && o_ctrl.init_n == $past(i_pwdata[2]))
        else $error("control write lost");
    chk_select_write: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        wr_acc && i_pstrb[0] && i_paddr == {2'b00, ppp_pkg::PPP_ADDR_CONTROL}
        |=> o_ctrl.select_n == $past(i_pwdata[3])) else $error("select write lost");
    chk_irq_gated: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        !irq_st_r && !ctl_r[4] |=> !irq_st_r) else $error("irq set while disabled");
    chk_irq_on_ack: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        ack_fall && ctl_r[4] |=> irq_st_r) else $error("ack irq missed");
    chk_oe_gate: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        ctl_r[5] |-> o_data_oe == 8'h00) else $error("data driven while disabled");
    chk_data_write: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        wr_acc && i_pstrb[0] && i_paddr == {2'b00, ppp_pkg::PPP_ADDR_DATA}
        |=> o_data_out == $past(i_pwdata[7:0])) else $error("data write lost");
    chk_status_ro: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        wr_acc && i_paddr == {2'b00, ppp_pkg::PPP_ADDR_STATUS}
        |=> $stable(data_r) && $stable(ctl_r)) else $error("status write had effect");
    chk_status_read: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        rd_acc && i_paddr == {2'b00, ppp_pkg::PPP_ADDR_STATUS}
        |=> o_prdata[2:0] == 3'b000 && o_prdata[7] == !$past(stat.busy)
            && o_prdata[3] == $past(stat.error_n) && o_prdata[4] == $past(stat.online_indication)
            && o_prdata[5] == $past(stat.paper_out_n) && o_prdata[6] == $past(stat.ack_n))
        else $error("status read wrong");
endmodule // ppp_port

// *** bench/ppp_printer_model.sv ***
// Behavioural printer on the far side of the parallel port
`timescale 1ns/1ps
module ppp_printer_model (
    input  wire logic               i_core_clk,
    input  wire ppp_pkg::ppp_ctrl_t i_ctrl,
    input  wire logic [7:0]         i_data,
    input  wire logic [2:0]         i_fault,
    output ppp_pkg::ppp_status_t    o_status,
    output logic [7:0]              o_byte
);
    // ****************************************
    // Byte capture and handshake
    // ****************************************
    logic     strobe_q = 1'b1;
    int       cnt      = 0;
    initial o_byte = 8'h00;
    // Strobe falling edge takes the byte; busy, then a two-cycle acknowledge
    always @(posedge i_core_clk) begin
        strobe_q <= i_ctrl.strobe_n;
        if (strobe_q && !i_ctrl.strobe_n && cnt == 0) begin
            o_byte <= i_data;
            cnt    <= 8;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
    assign o_status.busy              = (cnt != 0);
    assign o_status.ack_n             = !(cnt inside {1, 2});
    assign o_status.error_n           = !i_fault[0];
    assign o_status.paper_out_n       = !i_fault[1];
    assign o_status.online_indication = !i_fault[2];
endmodule // ppp_printer_model

// *** bench/tb_ppp_port.sv ***
// Self-checking testbench for the parallel printer port
`timescale 1ns/1ps
module tb_ppp_port;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic                 clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [15:0]          paddr  = 16'h0000;
    logic [31:0]          pwdata = 32'h0000_0000;
    logic [2:0]           fault  = 3'b000;
    logic [31:0]          rd, prdata;
    logic                 err, pready, pslverr, irq;
    logic [7:0]           dout, doe, wire_d, pbyte;
    ppp_pkg::ppp_status_t st;
    ppp_pkg::ppp_ctrl_t   ctl;
    int                   err_count = 0, check_count = 0;
    always #12.5 clk = ~clk;
    // Undriven data lines show the inverse of the last byte
    assign wire_d = (dout & doe) | (~dout & ~doe);
    ppp_port i_ppp_port (.i_core_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hf), .o_pready(pready), .o_prdata(prdata),
        .o_pslverr(pslverr), .i_status(st), .i_data_in(wire_d), .o_ctrl(ctl), .o_data_out(dout),
        .o_data_oe(doe), .o_irq(irq));
    ppp_printer_model i_ppp_printer_model (.i_core_clk(clk), .i_ctrl(ctl), .i_data(wire_d),
        .i_fault(fault), .o_status(st), .o_byte(pbyte));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [13:0] a, input logic [7:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= {2'b00, a};
        pwdata <= {24'h00_0000, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
        @(negedge clk);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        apb(1'b0, ppp_pkg::PPP_ADDR_CONTROL, 8'h00);
        chk("control", rd, 32'h0000_000f);
        chk("pins", {ctl, doe, irq}, {19'h0_0000, 4'hf, 8'hff, 1'b0});
        repeat (6) @(posedge clk);
        apb(1'b0, ppp_pkg::PPP_ADDR_STATUS, 8'h00);
        chk("status", rd, 32'h0000_00f8);
    endtask
    task automatic t_ctrl();
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, ppp_pkg::PPP_ADDR_CONTROL, 8'h0f ^ (8'h01 << i));
            chk("ctrl pins", ctl, 4'hf ^ (4'h8 >> i));
        end
        apb(1'b1, ppp_pkg::PPP_ADDR_CONTROL, 8'hcf);
        chk("ctrl pins", ctl, 4'hf);
        apb(1'b0, ppp_pkg::PPP_ADDR_CONTROL, 8'h00);
        chk("control", rd, 32'h0000_000f);
        repeat (20) @(posedge clk);
    endtask
    task automatic t_oe();
        apb(1'b1, ppp_pkg::PPP_ADDR_DATA, 8'h3c);
        apb(1'b1, ppp_pkg::PPP_ADDR_CONTROL, 8'h2f);
        chk("lines off", {doe, wire_d}, {8'h00, 8'hc3});
        apb(1'b1, ppp_pkg::PPP_ADDR_CONTROL, 8'h0f);
        chk("lines on", {doe, wire_d}, {8'hff, 8'h3c});
    endtask
    task automatic t_status();
        for (int f = 0; f < 8; f++) begin
            @(posedge clk);
            fault <= f[2:0];
            repeat (6) @(posedge clk);
            apb(1'b1, ppp_pkg::PPP_ADDR_STATUS, 8'h00);
            apb(1'b0, ppp_pkg::PPP_ADDR_STATUS, 8'h00);
            chk("status", rd, {24'h00_0000, 2'b11, ~f[1], ~f[2], ~f[0], 3'b000});
        end
        @(posedge clk);
        fault <= 3'b000;
        repeat (6) @(posedge clk);
    endtask
    task automatic t_print(input logic en, input logic [7:0] b);
        apb(1'b1, ppp_pkg::PPP_ADDR_DATA, b);
        do apb(1'b0, ppp_pkg::PPP_ADDR_STATUS, 8'h00); while (rd[7] !== 1'b1);
        apb(1'b1, ppp_pkg::PPP_ADDR_CONTROL, {3'b000, en, 4'he});
        apb(1'b1, ppp_pkg::PPP_ADDR_CONTROL, {3'b000, en, 4'hf});
        repeat (3) @(posedge clk);
        apb(1'b0, ppp_pkg::PPP_ADDR_STATUS, 8'h00);
        chk("busy", rd[7], 1'b0);
        repeat (20) @(posedge clk);
        chk("byte", pbyte, b);
        apb(1'b0, ppp_pkg::PPP_ADDR_IRQ_ST, 8'h00);
        chk("irq status", rd, {24'h00_0000, 7'h00, en});
    endtask
    task automatic t_irq();
        apb(1'b1, ppp_pkg::PPP_ADDR_IRQ_MSK, 8'h00);
        t_print(1'b1, 8'ha5);
        chk("irq masked", irq, 1'b0);
        apb(1'b1, ppp_pkg::PPP_ADDR_IRQ_MSK, 8'h01);
        chk("irq raised", irq, 1'b1);
        apb(1'b1, ppp_pkg::PPP_ADDR_IRQ_ST, 8'h01);
        chk("irq cleared", irq, 1'b0);
        t_print(1'b0, 8'h5a);
        chk("irq disabled", irq, 1'b0);
    endtask
    task automatic t_unmapped();
        apb(1'b1, 14'h3ff0, 8'hff);
        apb(1'b0, 14'h3ff0, 8'h00);
        chk("slverr", err, 1'b1);
        chk("unmapped data", rd, 32'h0000_0000);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_ctrl();
        t_oe();
        t_status();
        t_irq();
        t_unmapped();
        tally_and_finish();
    end
    initial begin
        repeat (4000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end
endmodule // tb_ppp_port
